// [channel_qualifier.v]
// One input channel: hysteresis, polarity, delays and rise counter
`timescale 1ns/1ps
`default_nettype none
`include "dig_in_map.vh"
module channel_qualifier (
  input wire core_clk,
  input wire rstn,
  input wire scan_tick,
  input wire ms_tick,
  input wire nc_pol,
  input wire alternating_supply_mode,
  input wire [`THR_W-1:0] upper_trip_level,
  input wire [`THR_W-1:0] lower_trip_level,
  input wire [`DLY_W-1:0] rise_qualify_delay,
  input wire [`DLY_W-1:0] fall_qualify_delay,
  input wire [`VOLT_W-1:0] channel_voltage_reading,
  input wire rise_event_count_clear,
  output reg raw_state,
  output reg input_channel_n,
  output reg [`CNT_W-1:0] rise_event_count
);
  wire [`VOLT_W-1:0] upper_mv;
  wire [`VOLT_W-1:0] prog_lower_mv;
  wire [`VOLT_W-1:0] ac_lower_mv;
  wire [`VOLT_W-1:0] lower_mv;
  wire above_upper;
  wire below_lower;
  wire target;
  wire [`ELAP_W-1:0] rise_need;
  wire [`ELAP_W-1:0] fall_need;
  wire [`ELAP_W-1:0] need;
  reg [`ELAP_W-1:0] elapsed_ff;
  reg [`ELAP_W-1:0] nxt_elapsed;
  reg nxt_raw;
  reg nxt_qual;

  assign upper_mv = upper_trip_level * `STEP_MV;
  assign prog_lower_mv = lower_trip_level * `STEP_MV;
  assign ac_lower_mv = upper_trip_level * `AC_REL_MV;
  // AC mode replaces the programmed release level
  assign lower_mv = alternating_supply_mode ? ac_lower_mv : prog_lower_mv;
  assign above_upper = channel_voltage_reading > upper_mv;
  assign below_lower = channel_voltage_reading < lower_mv;
  // Polarity flips the energized level
  assign target = raw_state ^ nc_pol;
  assign rise_need = {1'b0, rise_qualify_delay};
  // Extra drop-off so zero crossings do not release
  assign fall_need = alternating_supply_mode ?
    {1'b0, fall_qualify_delay} + `AC_EXTRA_MS : {1'b0, fall_qualify_delay};
  assign need = target ? rise_need : fall_need;

  always @* begin
    nxt_raw = raw_state;
    if (scan_tick) begin
      if (above_upper) begin
        nxt_raw = 1'b1;
      end else if (below_lower) begin
        nxt_raw = 1'b0;
      end
      // Between the two levels the last state holds
    end
  end

  always @* begin
    nxt_qual = input_channel_n;
    nxt_elapsed = elapsed_ff;
    if (target == input_channel_n) begin
      nxt_elapsed = {`ELAP_W{1'b0}};
    end else begin
      if (ms_tick && elapsed_ff != {`ELAP_W{1'b1}}) begin
        nxt_elapsed = elapsed_ff + 1'b1;
      end
      // State only moves on the scan boundary
      if (scan_tick && elapsed_ff >= need) begin
        nxt_qual = target;
        nxt_elapsed = {`ELAP_W{1'b0}};
      end
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      raw_state <= 1'b0;
      input_channel_n <= 1'b0;
      elapsed_ff <= {`ELAP_W{1'b0}};
      rise_event_count <= {`CNT_W{1'b0}};
    end else begin
      raw_state <= nxt_raw;
      input_channel_n <= nxt_qual;
      elapsed_ff <= nxt_elapsed;
      // A rise in the clear cycle still counts
      if (nxt_qual && !input_channel_n) begin
        if (rise_event_count_clear) begin
          rise_event_count <= {{(`CNT_W-1){1'b0}}, 1'b1};
        end else begin
          rise_event_count <= rise_event_count + 1'b1;
        end
      end else if (rise_event_count_clear) begin
        rise_event_count <= {`CNT_W{1'b0}};
      end
    end
  end
endmodule
`default_nettype wire

// [dig_in_checker_properties.sv]
// Bus, scan and output timing checks for the input qualifier
`timescale 1ns/1ps
`default_nettype none
`include "dig_in_map.vh"
module dig_in_checker #(
  parameter [`TICK_W-1:0] SCAN_CYCLES = 20
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [`CHAN_COUNT-1:0] input_channel_n,
  input wire logic scan_tick
);
  logic [`TICK_W-1:0] since_ff;
  logic seen_ff;
  logic rd_ff;
  wire logic take = hsel && htrans[1] && hready;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // First period after reset has a loose start, so it is skipped
  always @(posedge core_clk) begin
    if (!rstn) begin
      since_ff <= '0;
      seen_ff <= 1'b0;
      rd_ff <= 1'b0;
    end else begin
      since_ff <= scan_tick ? '0 : since_ff + 1'b1;
      seen_ff <= seen_ff | scan_tick;
      rd_ff <= take && !hwrite;
    end
  end
  chk_tick_period: assert property (
    scan_tick && seen_ff |-> since_ff == SCAN_CYCLES - 1'b1)
    else $error("scan period wrong");
  chk_tick_pulse: assert property (scan_tick |=> !scan_tick)
    else $error("scan tick too long");
  chk_chan_on_scan: assert property (
    $changed(input_channel_n) |-> $past(scan_tick))
    else $error("state changed off the scan");
  chk_read_wait: assert property (
    take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase timing wrong");
  chk_write_ready: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  chk_wait_cause: assert property (!hreadyout |-> rd_ff)
    else $error("wait state outside a read");
  chk_rdata_load: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved outside a read");
  chk_okay_resp: assert property (hresp == 1'b0)
    else $error("error response");
  chk_reset_state: assert property (disable iff (1'b0)
    !rstn |=> input_channel_n == '0 && !scan_tick && hreadyout)
    else $error("outputs not cleared by reset");
  cover property (take && !hwrite);
  cover property ($rose(input_channel_n[3]));
  cover property (scan_tick && seen_ff);
endmodule
bind digital_input_qualifier dig_in_checker #(.SCAN_CYCLES(SCAN_CYCLES))
  dig_in_checker_inst (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scan_tick(scan_tick),
  .input_channel_n(input_channel_n));
`default_nettype wire

// [dig_in_map.vh]
// Address map, field layout, defaults and timing for the input qualifier
`ifndef DIG_IN_MAP_VH
`define DIG_IN_MAP_VH

`define CHAN_COUNT 8
`define CHAN_SEL_W 3
`define VOLT_W 19
`define THR_W 11
`define DLY_W 21
`define ELAP_W 22
`define CNT_W 32

// Byte address = channel * 0x20 + register index * 4
`define ADDR_CHAN_HI 7
`define ADDR_CHAN_LO 5
`define ADDR_IDX_HI 4
`define ADDR_IDX_LO 2
`define ADDR_TOP_HI 31
`define ADDR_TOP_LO 8
`define ADDR_TOP_ZERO 24'h000000

`define IDX_CFG 3'h0
`define IDX_UPPER 3'h1
`define IDX_LOWER 3'h2
`define IDX_RISE 3'h3
`define IDX_FALL 3'h4
`define IDX_COUNT 3'h5
`define IDX_VOLT 3'h6
`define IDX_STATE 3'h7

`define CFG_NC_BIT 0
`define CFG_AC_BIT 1
`define CFG_CLR_BIT 2
`define STATE_QUAL_BIT 0
`define STATE_RAW_BIT 1

// Thresholds in 0.1 V steps, voltage in mV
`define UPPER_RST 11'h370
`define LOWER_RST 11'h258
`define DLY_RST 21'h000000
`define STEP_MV 8'h64
`define AC_REL_MV 8'h0a
`define AC_EXTRA_MS 22'h00001e

`define CLK_KHZ 40000
`define MS_TIME_MS 1
`define SCAN_TIME_MS 5
`define TICK_W 18
// 1 ms and 5 ms at 40 MHz, sized to the tick counters
`define MS_CYCLES_RST 18'h09c40
`define SCAN_CYCLES_RST 18'h30d40

`define HTRANS_NONSEQ_BIT 1
`define WORD_ZERO 32'h00000000

`endif

// [digital_input_qualifier.v]
// Eight-channel digital input qualifier with AHB-Lite register access
//
// The register addresses and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dig_in_map.vh"
module digital_input_qualifier #(
  parameter [`TICK_W-1:0] MS_CYCLES = `MS_CYCLES_RST,
  parameter [`TICK_W-1:0] SCAN_CYCLES = `SCAN_CYCLES_RST
) (
  input wire core_clk,
  input wire rstn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire meas_valid,
  input wire [`CHAN_SEL_W-1:0] meas_chan,
  input wire [`VOLT_W-1:0] meas_mv,
  output wire [`CHAN_COUNT-1:0] input_channel_n,
  output wire scan_tick
);
  // Per-channel settings, held separately for each input
  reg nc_ff [0:`CHAN_COUNT-1];
  reg ac_ff [0:`CHAN_COUNT-1];
  reg [`THR_W-1:0] upper_ff [0:`CHAN_COUNT-1];
  reg [`THR_W-1:0] lower_ff [0:`CHAN_COUNT-1];
  reg [`DLY_W-1:0] rise_dly_ff [0:`CHAN_COUNT-1];
  reg [`DLY_W-1:0] fall_dly_ff [0:`CHAN_COUNT-1];
  reg [`VOLT_W-1:0] volt_ff [0:`CHAN_COUNT-1];
  reg [`CHAN_COUNT-1:0] clr_ff;
  reg [`CHAN_COUNT-1:0] nxt_clr;

  // Per-channel results
  wire [`CHAN_COUNT-1:0] raw_state;
  wire [`CNT_W-1:0] count_w [0:`CHAN_COUNT-1];

  // Tick dividers
  reg [`TICK_W-1:0] ms_cnt_ff;
  reg [`TICK_W-1:0] scan_cnt_ff;
  reg ms_tick_ff;
  reg scan_tick_ff;

  // Bus data-phase state
  reg dp_valid_ff;
  reg dp_write_ff;
  reg dp_mapped_ff;
  reg [`CHAN_SEL_W-1:0] dp_chan_ff;
  reg [2:0] dp_idx_ff;
  reg rd_done_ff;
  reg [31:0] rd_mux;

  wire take;
  wire addr_mapped;
  wire wr_now;
  wire rd_load;

  integer i;
  genvar g;

  // Both ticks come from one free-running clock; no second domain
  always @(posedge core_clk) begin
    if (!rstn) begin
      ms_cnt_ff <= {`TICK_W{1'b0}};
      ms_tick_ff <= 1'b0;
    end else if (ms_cnt_ff == MS_CYCLES - 1'b1) begin
      ms_cnt_ff <= {`TICK_W{1'b0}};
      ms_tick_ff <= 1'b1;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 1'b1;
      ms_tick_ff <= 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      scan_cnt_ff <= {`TICK_W{1'b0}};
      scan_tick_ff <= 1'b0;
    end else if (scan_cnt_ff == SCAN_CYCLES - 1'b1) begin
      scan_cnt_ff <= {`TICK_W{1'b0}};
      scan_tick_ff <= 1'b1;
    end else begin
      scan_cnt_ff <= scan_cnt_ff + 1'b1;
      scan_tick_ff <= 1'b0;
    end
  end

  assign scan_tick = scan_tick_ff;

  // Latest front-end reading per channel, kept apart from the state
  always @(posedge core_clk) begin
    if (!rstn) begin
      for (i = 0; i < `CHAN_COUNT; i = i + 1) begin
        volt_ff[i] <= {`VOLT_W{1'b0}};
      end
    end else if (meas_valid) begin
      volt_ff[meas_chan] <= meas_mv;
    end
  end

  // Address phase is captured when the bus is ready
  assign take = hsel && htrans[`HTRANS_NONSEQ_BIT] && hready;
  assign addr_mapped =
    haddr[`ADDR_TOP_HI:`ADDR_TOP_LO] == `ADDR_TOP_ZERO;

  always @(posedge core_clk) begin
    if (!rstn) begin
      dp_valid_ff <= 1'b0;
      dp_write_ff <= 1'b0;
      dp_mapped_ff <= 1'b0;
      dp_chan_ff <= {`CHAN_SEL_W{1'b0}};
      dp_idx_ff <= 3'h0;
    end else if (hready) begin
      dp_valid_ff <= take;
      dp_write_ff <= hwrite;
      dp_mapped_ff <= addr_mapped;
      dp_chan_ff <= haddr[`ADDR_CHAN_HI:`ADDR_CHAN_LO];
      dp_idx_ff <= haddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
    end
  end

  // Reads take one wait state so the data leaves a flip-flop
  assign rd_load = dp_valid_ff && !dp_write_ff && !rd_done_ff;
  assign hreadyout = !rd_load;
  assign hresp = 1'b0;
  assign wr_now = dp_valid_ff && dp_write_ff && dp_mapped_ff;

  always @(posedge core_clk) begin
    if (!rstn) begin
      rd_done_ff <= 1'b0;
    end else if (hready) begin
      rd_done_ff <= 1'b0;
    end else if (rd_load) begin
      rd_done_ff <= 1'b1;
    end
  end

  always @* begin
    rd_mux = `WORD_ZERO;
    if (dp_mapped_ff) begin
      case (dp_idx_ff)
        `IDX_CFG: begin
          rd_mux[`CFG_NC_BIT] = nc_ff[dp_chan_ff];
          rd_mux[`CFG_AC_BIT] = ac_ff[dp_chan_ff];
        end
        `IDX_UPPER: begin
          rd_mux[`THR_W-1:0] = upper_ff[dp_chan_ff];
        end
        `IDX_LOWER: begin
          rd_mux[`THR_W-1:0] = lower_ff[dp_chan_ff];
        end
        `IDX_RISE: begin
          rd_mux[`DLY_W-1:0] = rise_dly_ff[dp_chan_ff];
        end
        `IDX_FALL: begin
          rd_mux[`DLY_W-1:0] = fall_dly_ff[dp_chan_ff];
        end
        `IDX_COUNT: begin
          rd_mux = count_w[dp_chan_ff];
        end
        `IDX_VOLT: begin
          rd_mux[`VOLT_W-1:0] = volt_ff[dp_chan_ff];
        end
        `IDX_STATE: begin
          rd_mux[`STATE_QUAL_BIT] = input_channel_n[dp_chan_ff];
          rd_mux[`STATE_RAW_BIT] = raw_state[dp_chan_ff];
        end
        default: begin
          rd_mux = `WORD_ZERO;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      hrdata <= `WORD_ZERO;
    end else if (rd_load) begin
      hrdata <= rd_mux;
    end
  end

  // Settings writes land in the data phase
  always @(posedge core_clk) begin
    if (!rstn) begin
      for (i = 0; i < `CHAN_COUNT; i = i + 1) begin
        nc_ff[i] <= 1'b0;
        ac_ff[i] <= 1'b0;
        upper_ff[i] <= `UPPER_RST;
        lower_ff[i] <= `LOWER_RST;
        rise_dly_ff[i] <= `DLY_RST;
        fall_dly_ff[i] <= `DLY_RST;
      end
    end else if (wr_now) begin
      case (dp_idx_ff)
        `IDX_CFG: begin
          nc_ff[dp_chan_ff] <= hwdata[`CFG_NC_BIT];
          ac_ff[dp_chan_ff] <= hwdata[`CFG_AC_BIT];
        end
        `IDX_UPPER: begin
          upper_ff[dp_chan_ff] <= hwdata[`THR_W-1:0];
        end
        `IDX_LOWER: begin
          lower_ff[dp_chan_ff] <= hwdata[`THR_W-1:0];
        end
        `IDX_RISE: begin
          rise_dly_ff[dp_chan_ff] <= hwdata[`DLY_W-1:0];
        end
        `IDX_FALL: begin
          fall_dly_ff[dp_chan_ff] <= hwdata[`DLY_W-1:0];
        end
        default: begin
          nc_ff[dp_chan_ff] <= nc_ff[dp_chan_ff];
        end
      endcase
    end
  end

  // Clear is a one-cycle pulse; the stored bit never reads back
  always @* begin
    nxt_clr = {`CHAN_COUNT{1'b0}};
    if (wr_now && dp_idx_ff == `IDX_CFG && hwdata[`CFG_CLR_BIT]) begin
      nxt_clr[dp_chan_ff] = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      clr_ff <= {`CHAN_COUNT{1'b0}};
    end else begin
      clr_ff <= nxt_clr;
    end
  end

  generate
    for (g = 0; g < `CHAN_COUNT; g = g + 1) begin : chan
      channel_qualifier u_chan (
        .core_clk(core_clk),
        .rstn(rstn),
        .scan_tick(scan_tick_ff),
        .ms_tick(ms_tick_ff),
        .nc_pol(nc_ff[g]),
        .alternating_supply_mode(ac_ff[g]),
        .upper_trip_level(upper_ff[g]),
        .lower_trip_level(lower_ff[g]),
        .rise_qualify_delay(rise_dly_ff[g]),
        .fall_qualify_delay(fall_dly_ff[g]),
        .channel_voltage_reading(volt_ff[g]),
        .rise_event_count_clear(clr_ff[g]),
        .raw_state(raw_state[g]),
        .input_channel_n(input_channel_n[g]),
        .rise_event_count(count_w[g])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// [fe_model.sv]
// Voltage front end model streaming one reading per channel in turn
`timescale 1ns/1ps
`default_nettype none
`include "dig_in_map.vh"
module fe_model (
  input wire logic core_clk,
  output logic meas_valid = 1'b0,
  output logic [`CHAN_SEL_W-1:0] meas_chan = '0,
  output logic [`VOLT_W-1:0] meas_mv = '0
);
  logic [`VOLT_W-1:0] volt [`CHAN_COUNT] = '{default: '0};
  logic [1:0] gap_ff = 2'h0;
  // Data toggles between strobes so a stale value never looks valid
  always @(posedge core_clk) begin
    gap_ff <= gap_ff == 2'h2 ? 2'h0 : gap_ff + 2'h1;
    meas_valid <= gap_ff == 2'h0;
    if (gap_ff == 2'h0) begin
      meas_chan <= meas_chan + 1'b1;
      meas_mv <= volt[meas_chan + 1'b1];
    end else begin
      meas_mv <= ~meas_mv;
    end
  end
endmodule
`default_nettype wire

// [tb_digital_input_qualifier.sv]
// Self-checking bench for the eight-channel input qualifier
`timescale 1ns/1ps
`default_nettype none
`include "dig_in_map.vh"
module tb_digital_input_qualifier;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, meas_valid, scan_tick;
  logic [`CHAN_SEL_W-1:0] meas_chan;
  logic [`VOLT_W-1:0] meas_mv;
  logic [`CHAN_COUNT-1:0] input_channel_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  digital_input_qualifier #(.MS_CYCLES(18'h4), .SCAN_CYCLES(18'h14))
    digital_input_qualifier_inst (.core_clk(core_clk), .rstn(rstn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .meas_valid(meas_valid),
    .meas_chan(meas_chan), .meas_mv(meas_mv), .scan_tick(scan_tick),
    .input_channel_n(input_channel_n));
  fe_model fe_model_inst (.core_clk(core_clk), .meas_valid(meas_valid),
    .meas_chan(meas_chan), .meas_mv(meas_mv));
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Plan needs about 2400 cycles; ceiling leaves ample margin
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: read %h expected %h", $time, got, exp);
    end
  endtask
  task chk_pin(input logic got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: state %b expected %b", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task rdc(input logic [31:0] a, exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task scans(input int n);
    repeat (n) @(posedge scan_tick);
    repeat (2) @(posedge core_clk);
  endtask
  task sv(input int c, v);
    fe_model_inst.volt[c] = `VOLT_W'(v);
  endtask
  function automatic logic [31:0] ra(input int c, i);
    return 32'(c * 32 + i * 4);
  endfunction
  function automatic logic exp_raw(input int v, up, lo, input logic prev);
    if (v > up * `STEP_MV)
      return 1'b1;
    if (v < lo * `STEP_MV)
      return 1'b0;
    return prev;
  endfunction
  initial begin
    int v5, v6, seed;
    logic r5 = 1'b0, r6 = 1'b0, q5 = 1'b0, q6 = 1'b1;
    int c5 = 0, c6 = 1;
    int corner [4] = '{32'h157c0, 32'h157c1, 32'hea60, 32'hea5f};
    seed = $urandom(32'h0f84);
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    for (int c = 0; c < 8; c++) begin
      rdc(ra(c, 0), 32'h0);
      rdc(ra(c, 1), 32'h370);
      rdc(ra(c, 2), 32'h258);
      rdc(ra(c, 3), 32'h0);
      rdc(ra(c, 4), 32'h0);
      rdc(ra(c, 5), 32'h0);
    end
    xfer(1'b1, ra(7, 1), 32'h12c);
    rdc(ra(7, 1), 32'h12c);
    xfer(1'b1, 32'h100 | ra(6, 1), 32'h5);
    rdc(32'h100 | ra(6, 1), 32'h0);
    rdc(ra(6, 1), 32'h370);
    xfer(1'b1, ra(6, 0), 32'h1);
    scans(3);
    chk_pin(input_channel_n[6], 1'b1);
    // Corner levels first, then random readings on both polarities
    for (int i = 0; i < 16; i++) begin
      v5 = i < 4 ? corner[i] : $urandom % 275001;
      v6 = $urandom % 275001;
      sv(5, v5);
      sv(6, v6);
      scans(4);
      r5 = exp_raw(v5, 880, 600, r5);
      r6 = exp_raw(v6, 880, 600, r6);
      c5 += r5 && !q5;
      c6 += !r6 && !q6;
      q5 = r5;
      q6 = !r6;
      chk_pin(input_channel_n[5], q5);
      chk_pin(input_channel_n[6], q6);
      rdc(ra(5, 6), v5);
      rdc(ra(5, 7), {30'h0, r5, q5});
    end
    xfer(1'b1, ra(5, 5), 32'h7);
    rdc(ra(5, 5), c5);
    rdc(ra(6, 5), c6);
    xfer(1'b1, ra(5, 0), 32'h4);
    repeat (3) @(posedge core_clk);
    rdc(ra(5, 5), 32'h0);
    xfer(1'b1, ra(2, 3), 32'hc);
    xfer(1'b1, ra(2, 4), 32'hc);
    for (int k = 0; k < 2; k++) begin
      sv(2, k ? 0 : 32'h186a0);
      scans(3);
      chk_pin(input_channel_n[2], k);
      scans(6);
      chk_pin(input_channel_n[2], !k);
    end
    xfer(1'b1, ra(3, 0), 32'h2);
    sv(3, 32'h186a0);
    scans(4);
    sv(3, 32'h7530);
    scans(10);
    chk_pin(input_channel_n[3], 1'b1);
    sv(3, 32'h1f40);
    scans(4);
    chk_pin(input_channel_n[3], 1'b1);
    scans(10);
    chk_pin(input_channel_n[3], 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire
